//--- sms_peer.sv
// partner: external spi device, slave on the port clock or master over it
`timescale 1ns/100ps
module sms_peer (
   input  wire logic       pclk,
   input  wire logic       sck_out,
   input  wire logic       sdo,
   input  wire logic       clock_polarity,
   input  wire logic       cke,
   input  wire logic [7:0] tx,
   output logic            sck_in,
   output logic            sdi,
   output logic            ss_n,
   output logic [7:0]      rx
);
   logic [7:0] sh = 8'h00;
   logic       prev = 1'b0;
   logic       first = 1'b1;
   logic       mst = 1'b0;
   initial begin
      sck_in = 1'b0;
      sdi = 1'b0;
      ss_n = 1'b1;
      rx = 8'h00;
   end
   task automatic load();
      sh <= tx;
      sdi <= tx[7];
      prev <= sck_out;
      first <= 1'b1;
   endtask
   // slave role: first bit stands before any edge
   always @(posedge pclk) begin
      if (!mst && sck_out !== prev) begin
         prev <= sck_out;
         first <= 1'b0;
         if ((sck_out != clock_polarity) == cke) begin
            if (!first) begin
               sh <= {sh[6:0], 1'b0};
               sdi <= sh[6];
            end
         end else
            rx <= {rx[6:0], sdo};
      end
   end
   // master role, port edge select clear; short counts abort mid byte
   task automatic xfer(input int halves);
      @(posedge pclk);
      mst <= 1'b1;
      ss_n <= 1'b0;
      sck_in <= clock_polarity;
      sh <= tx;
      sdi <= tx[7];
      for (int i = 0; i < halves; i++) begin
         repeat (3) @(posedge pclk);
         sck_in <= ~sck_in;
         if (i % 2 == 0)
            rx <= {rx[6:0], sdo};
         else begin
            sh <= {sh[6:0], 1'b0};
            sdi <= sh[6];
         end
      end
      repeat (3) @(posedge pclk);
      ss_n <= 1'b1;
      sdi <= ~sdi;
      mst <= 1'b0;
   endtask
endmodule

//--- sms_pkg.sv
// package: register map, fields, modes and counts of the spi port
package sms_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] OFS_STATUS  = 12'h000;
   localparam logic [11:0] OFS_CONTROL = 12'h004;
   localparam logic [11:0] OFS_DATA    = 12'h008;
   localparam logic [11:0] OFS_FLAG    = 12'h00C;

   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam int         STAT_SMP    = 7;
   localparam int         STAT_CKE    = 6;
   localparam int         STAT_BF     = 0;
   localparam int         CTL_WRITE_COLLISION    = 7;
   localparam int         CTL_OVF     = 6;
   localparam int         CTL_EN      = 5;
   localparam int         CTL_CKP     = 4;
   localparam int         FLAG_DONE   = 0;
   localparam logic [7:0] STATUS_RST  = 8'h00;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] DATA_RST    = 8'h00;

   // ************************************************************
   // mode field codes
   // ************************************************************
   localparam logic [3:0] MODE_M_DIV4  = 4'h0;
   localparam logic [3:0] MODE_M_DIV16 = 4'h1;
   localparam logic [3:0] MODE_M_DIV64 = 4'h2;
   localparam logic [3:0] MODE_M_TMR   = 4'h3;
   localparam logic [3:0] MODE_S_SS    = 4'h4;
   localparam logic [3:0] MODE_S_NOSS  = 4'h5;

   // ************************************************************
   // counts, in ns, pclk cycles, serial clock half periods or bits
   // ************************************************************
   localparam int         CLK_PERIOD_NS  = 40;
   localparam logic [4:0] LIM_DIV4       = 5'h01;
   localparam logic [4:0] LIM_DIV16      = 5'h07;
   localparam logic [4:0] LIM_DIV64      = 5'h1F;
   localparam logic [4:0] HALF_FIRST     = 5'h00;
   localparam logic [4:0] HALF_LAST      = 5'h0F;
   localparam logic [4:0] HALF_LAST_LATE = 5'h10;
   localparam logic [2:0] LAST_BIT       = 3'h7;

   typedef enum logic {SMS_IDLE, SMS_SHIFT} sms_state_e;

endpackage

//--- sms_port.sv
// module: spi master/slave port with apb registers and shift engine
`timescale 1ns/100ps

module sms_port
   import sms_pkg::*;
(
   input  logic              pclk,
   input  logic              presetn,
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [ADDR_W-1:0] paddr,
   input  logic [31:0]       pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  logic              sck_in,
   output logic              sck_out,
   output logic              sck_oe,
   input  logic              sdi,
   output logic              sdo,
   output logic              sdo_oe,
   input  logic              ss_n,
   input  logic              timer_two_output,
   input  logic              sleep,
   output logic              wake
);

   // ************************************************************
   // state
   // ************************************************************
   logic       sample_phase;
   logic       cke;
   logic       bf;
   logic       write_collision;
   logic       ovf;
   logic       en;
   logic       clock_polarity;
   logic [3:0] mode;
   logic       done_flag;
   logic [7:0] data_buffer;
   logic [7:0] shift_register;
   logic [7:0] rx_shift;
   logic [4:0] half;
   logic [2:0] bit_cnt;
   logic       sck_q;
   sms_state_e state;

   logic        setup;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_stat;
   logic        wr_ctl;
   logic        wr_data;
   logic        wr_flag;
   logic        rd_data;
   logic [31:0] rd_word;
   logic        mapped;

   logic       is_master;
   logic       is_slave;
   logic       gate_ok;
   logic       s_active;
   logic       busy;
   logic       load;
   logic       collision;
   logic [4:0] m_last;
   logic       m_tick;
   logic       m_tx;
   logic       m_smp;
   logic       m_done;
   logic       s_edge;
   logic       s_lead;
   logic       s_tx;
   logic       s_smp;
   logic       s_done;
   logic       tx_ev;
   logic       smp_ev;
   logic       done_ev;
   logic [7:0] rx_next;
   logic [7:0] captured;
   logic       overrun;

   logic       next_write_collision;
   logic       next_ovf;
   logic       next_bf;
   logic       next_done_flag;

   sms_rate_if rate ();

   sms_rate_gen u_rate (
      .pclk             (pclk),
      .presetn          (presetn),
      .timer_two_output (timer_two_output),
      .rate             (rate.gen)
   );

   // ************************************************************
   // apb decode
   // ************************************************************
   assign setup   = psel && !penable;
   assign wr_fire = psel && penable && pwrite && pready;
   assign rd_fire = psel && penable && !pwrite && pready;
   assign wr_stat = wr_fire && (paddr == OFS_STATUS);
   assign wr_ctl  = wr_fire && (paddr == OFS_CONTROL);
   assign wr_data = wr_fire && (paddr == OFS_DATA);
   assign wr_flag = wr_fire && (paddr == OFS_FLAG);
   assign rd_data = rd_fire && (paddr == OFS_DATA);

   always_comb begin
      rd_word = 32'h0000_0000;
      mapped  = 1'b1;
      unique case (paddr)
         OFS_STATUS:  rd_word = {24'h00_0000, sample_phase, cke, 5'h00, bf};
         OFS_CONTROL: rd_word = {24'h00_0000, write_collision, ovf, en, clock_polarity, mode};
         OFS_DATA:    rd_word = {24'h00_0000, data_buffer};
         OFS_FLAG:    rd_word = {31'h0000_0000, done_flag};
         default:     mapped  = 1'b0;
      endcase
   end

   // answer in the first access cycle; data and error captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         prdata  <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
         pslverr <= setup && !mapped;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_phase <= STATUS_RST[STAT_SMP];
         cke <= STATUS_RST[STAT_CKE];
      end else if (wr_stat) begin
         sample_phase <= pwdata[STAT_SMP];
         cke <= pwdata[STAT_CKE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en   <= CONTROL_RST[CTL_EN];
         clock_polarity  <= CONTROL_RST[CTL_CKP];
         mode <= CONTROL_RST[3:0];
      end else if (wr_ctl) begin
         en   <= pwdata[CTL_EN];
         clock_polarity  <= pwdata[CTL_CKP];
         mode <= pwdata[3:0];
      end
   end

   // ************************************************************
   // mode decode and transfer control
   // ************************************************************
   // reserved mode codes leave the port inert
   assign is_master = en && (mode[3:2] == 2'b00);
   assign is_slave  = en && ((mode == MODE_S_SS) || (mode == MODE_S_NOSS));
   assign gate_ok   = (mode == MODE_S_NOSS) || !ss_n;
   assign s_active  = is_slave && gate_ok;

   assign busy      = (state == SMS_SHIFT) || (bit_cnt != 3'h0);
   assign load      = wr_data && !busy;
   assign collision = wr_data && busy;

   // ************************************************************
   // master engine
   // ************************************************************
   // a late sample with edge select set needs one more half period
   assign m_last = (cke && sample_phase) ? HALF_LAST_LATE : HALF_LAST;
   assign m_tick = (state == SMS_SHIFT) && rate.tick;
   assign m_tx   = m_tick && (half <= HALF_LAST) &&
                   (cke ? !half[0] : (half[0] && (half != HALF_LAST)));
   assign m_smp  = m_tick && ((half[0] ^ sample_phase) == cke) &&
                   !(sample_phase && (half == HALF_FIRST));
   assign m_done = m_tick && (half == m_last);

   // sleep halts the master clock in place
   assign rate.run = (state == SMS_SHIFT) && !sleep;
   assign rate.sel = mode[1:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SMS_IDLE;
         half  <= HALF_FIRST;
      end else if (!is_master) begin
         state <= SMS_IDLE;
         half  <= HALF_FIRST;
      end else begin
         unique case (state)
            SMS_IDLE: begin
               if (load) begin
                  state <= SMS_SHIFT;
                  half  <= HALF_FIRST;
               end
            end
            SMS_SHIFT: begin
               if (m_tick) begin
                  if (half == m_last) begin
                     state <= SMS_IDLE;
                  end
                  half <= half + 5'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_out <= 1'b0;
      end else if (!is_master || state == SMS_IDLE) begin
         sck_out <= clock_polarity;
      end else if (m_tick && half <= HALF_LAST) begin
         sck_out <= !sck_out;
      end
   end

   // ************************************************************
   // slave engine
   // ************************************************************
   assign s_edge = sck_in != sck_q;
   assign s_lead = s_edge && (sck_in != clock_polarity);
   assign s_tx   = s_active && (cke ? s_lead : (s_edge && !s_lead));
   assign s_smp  = s_active && (cke ? (s_edge && !s_lead) : s_lead);
   assign s_done = s_smp && (bit_cnt == LAST_BIT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_q <= 1'b0;
      end else begin
         sck_q <= sck_in;
      end
   end

   // deselect mid-byte discards the partial byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt <= 3'h0;
      end else if (!s_active) begin
         bit_cnt <= 3'h0;
      end else if (s_smp) begin
         bit_cnt <= bit_cnt + 3'h1;
      end
   end

   // ************************************************************
   // shared data path
   // ************************************************************
   assign tx_ev   = is_master ? m_tx : s_tx;
   assign smp_ev  = is_master ? m_smp : s_smp;
   assign done_ev = is_master ? m_done : s_done;
   assign rx_next = {rx_shift[6:0], sdi};
   // master may finish one half period after its last sample
   assign captured = smp_ev ? rx_next : rx_shift;
   assign overrun  = s_done && bf;

   // shifter keeps the msb at the pin ahead of the first edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_register <= DATA_RST;
         sdo            <= 1'b0;
      end else if (load) begin
         shift_register <= cke ? pwdata[7:0] : {pwdata[6:0], 1'b0};
         sdo            <= pwdata[7];
      end else if (tx_ev) begin
         shift_register <= {shift_register[6:0], 1'b0};
         sdo            <= shift_register[7];
      end
   end

   // data-in is shifted only as master or active slave, the roles that drive data-out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_shift <= DATA_RST;
      end else if (smp_ev) begin
         rx_shift <= rx_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_buffer <= DATA_RST;
      end else if (load) begin
         data_buffer <= pwdata[7:0];
      end else if (done_ev && !overrun) begin
         data_buffer <= captured;
      end
   end

   // ************************************************************
   // status flags, set wins over clear
   // ************************************************************
   always_comb begin
      next_write_collision      = collision || (wr_ctl ? pwdata[CTL_WRITE_COLLISION] : write_collision);
      next_ovf       = overrun || (wr_ctl ? pwdata[CTL_OVF] : ovf);
      next_bf        = (done_ev && !overrun) || (bf && !rd_data);
      next_done_flag = done_ev || (done_flag && !(wr_flag && pwdata[FLAG_DONE]));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_collision      <= CONTROL_RST[CTL_WRITE_COLLISION];
         ovf       <= CONTROL_RST[CTL_OVF];
         bf        <= STATUS_RST[STAT_BF];
         done_flag <= 1'b0;
      end else begin
         write_collision      <= next_write_collision;
         ovf       <= next_ovf;
         bf        <= next_bf;
         done_flag <= next_done_flag;
      end
   end

   // ************************************************************
   // pin enables and wake
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_oe <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sck_oe <= is_master;
         sdo_oe <= is_master || s_active;
      end
   end

   // slave logic runs on pclk, which must keep running in sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake <= 1'b0;
      end else begin
         wake <= s_done && sleep;
      end
   end

endmodule

//--- sms_port_assertions.sv
// checker: port behaviour watched at the spi port's own pins
`timescale 1ns/100ps
module sms_port_assertions
   import sms_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              sck_out,
   input wire logic              sck_oe,
   input wire logic              sdo_oe,
   input wire logic              ss_n,
   input wire logic              sleep,
   input wire logic              wake
);
   localparam logic [9:0] QUIET      = 10'h258;
   localparam logic [9:0] IDLE_DIV4  = 10'h028;
   localparam logic [9:0] IDLE_DIV16 = 10'h088;
   localparam logic [9:0] IDLE_DIV64 = 10'h208;
   logic [7:0] ctl;
   logic [9:0] quiet;
   logic [9:0] idle_after;
   logic       rd_ok;
   assign rd_ok = psel && penable && pready && !pwrite;
   // sixteen half periods plus margin; timer rate is set outside, so no bound there
   assign idle_after = (ctl[1:0] == 2'h0) ? IDLE_DIV4 :
                       (ctl[1:0] == 2'h1) ? IDLE_DIV16 : IDLE_DIV64;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctl <= 8'h00;
      else if (psel && penable && pready && pwrite && paddr == OFS_CONTROL)
         ctl <= pwdata[7:0];
   end
   // a master byte starts only on a data write; sleep freezes its clock mid-byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         quiet <= 10'h000;
      else if (sleep || (psel && pwrite && (paddr == OFS_CONTROL || paddr == OFS_DATA)))
         quiet <= 10'h000;
      else if (quiet != QUIET)
         quiet <= quiet + 10'h001;
   end
   AST_OFF_PINS: assert property (!ctl[CTL_EN] |=> !sck_oe && !sdo_oe)
      else $error("pins driven while disabled");
   AST_SS_RELEASE: assert property (ctl[CTL_EN] && ctl[3:0] == MODE_S_SS && ss_n
      |=> !sdo_oe)
      else $error("data out driven while deselected");
   AST_SLAVE_PINS: assert property (ctl[CTL_EN] && ctl[3:0] == MODE_S_NOSS
      |=> sdo_oe && !sck_oe)
      else $error("slave pin ownership wrong");
   AST_IDLE_LEVEL: assert property (quiet >= idle_after && ctl[1:0] != 2'h3 && sck_oe
      |-> sck_out == ctl[CTL_CKP])
      else $error("serial clock not at idle level");
   AST_NO_MASTER_OVF: assert property (rd_ok && paddr == OFS_CONTROL && ctl[3:2] == 2'b00
      |-> !prdata[CTL_OVF])
      else $error("overflow seen in master mode");
   AST_STATUS_ZERO: assert property (rd_ok && paddr == OFS_STATUS
      |-> prdata[5:1] == 5'h00 && prdata[31:8] == 24'h00_0000)
      else $error("unused status bits set");
   AST_RESET_ABORT: assert property ($rose(presetn) |-> !sck_oe && !sdo_oe && !wake)
      else $error("pins active after reset");
   AST_WAKE_SLAVE: assert property (wake
      |-> (ctl[3:1] == 3'b010 && $past(sleep)) ##1 !wake)
      else $error("wake outside sleeping slave");
endmodule

bind sms_port sms_port_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe), .ss_n(ss_n),
   .sleep(sleep), .wake(wake));

//--- sms_port_test.sv
// testbench: registers, master and slave transfers of the spi port
`timescale 1ns/100ps
module sms_port_test
   import sms_pkg::*;
();
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 12'h000;
   logic [31:0]       pwdata = 32'h0000_0000;
   logic              timer_two_output = 1'b0;
   logic              sleep = 1'b0;
   logic              clock_polarity = 1'b0;
   logic              cke = 1'b0;
   logic [2:0]        tdiv = 3'h0;
   logic [31:0]       prdata, rd;
   logic              pready, pslverr, sck_out, sck_oe, sdo, sdo_oe, wake, sck_in, sdi, ss_n;
   logic              err;
   logic [7:0]        tx, ptx, prx, ctl, stat, keep;
   int                fail_count = 0;
   int                num_checks = 0;
   int                seed = 32'haa77e497;
   int                edges, wakes;
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      tdiv <= (tdiv == 3'h4) ? 3'h0 : tdiv + 3'h1;
      timer_two_output <= (tdiv == 3'h0);
   end
   always @(sck_out) if (sck_oe === 1'b1) edges++;
   always @(posedge pclk) if (wake === 1'b1) wakes++;
   sms_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe), .ss_n(ss_n), .timer_two_output(timer_two_output),
      .sleep(sleep), .wake(wake));
   sms_peer i_peer (.pclk(pclk), .sck_out(sck_out), .sdo(sdo), .clock_polarity(clock_polarity), .cke(cke),
      .tx(ptx), .sck_in(sck_in), .sdi(sdi), .ss_n(ss_n), .rx(prx));
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         check(0, 1, "no ready");
         results();
      end
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_FLAG, 8'h00);
         n++;
      end while (rd[FLAG_DONE] !== 1'b1 && n < 200);
      if (n >= 200) begin
         check(0, 1, "no done");
         results();
      end
      apb(1'b1, OFS_FLAG, 8'h01);
   endtask
   task automatic reset_vals();
      logic [ADDR_W-1:0] adr [4] = '{OFS_STATUS, OFS_CONTROL, OFS_DATA, OFS_FLAG};
      logic [7:0]        rst [4] = '{STATUS_RST, CONTROL_RST, DATA_RST, 8'h00};
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, adr[i], 8'h00);
         check(rd, {24'h00_0000, rst[i]}, "reset value");
      end
      apb(1'b0, 12'h010, 8'h00);
      check({err, rd[30:0]}, 32'h8000_0000, "unmapped");
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      reset_vals();
      $display("test reset done");
      for (int k = 0; k < 16; k++) begin
         tx = $random(seed);
         ptx = $random(seed);
         clock_polarity = k[2];
         cke = k[3];
         stat = {tx[0], cke, 6'h00};
         ctl = {3'b001, clock_polarity, 2'b00, 2'(k)};
         apb(1'b1, OFS_CONTROL, 8'h00);
         apb(1'b1, OFS_STATUS, stat);
         apb(1'b1, OFS_CONTROL, ctl);
         apb(1'b0, OFS_STATUS, 8'h00);
         check(rd, {24'h00_0000, stat}, "status");
         i_peer.load();
         edges = 0;
         apb(1'b1, OFS_DATA, tx);
         @(negedge pclk);
         check(sdo, tx[7], "data early");
         apb(1'b1, OFS_DATA, ~tx);
         wait_done();
         check(edges, 16, "sck edges");
         check(sck_out, clock_polarity, "sck idle");
         apb(1'b0, OFS_STATUS, 8'h00);
         check(rd, {24'h00_0000, stat | 8'h01}, "full");
         apb(1'b0, OFS_CONTROL, 8'h00);
         check(rd, {24'h00_0000, ctl | 8'h80}, "collision");
         apb(1'b0, OFS_DATA, 8'h00);
         check(rd, {24'h00_0000, ptx}, "master rx");
         apb(1'b0, OFS_STATUS, 8'h00);
         check(rd, {24'h00_0000, stat}, "read clears");
         check(prx, tx, "peer rx");
      end
      $display("test master done");
      clock_polarity = 1'b0;
      cke = 1'b0;
      apb(1'b1, OFS_CONTROL, 8'h00);
      apb(1'b1, OFS_STATUS, 8'h00);
      apb(1'b1, OFS_CONTROL, {4'b0010, MODE_S_NOSS});
      tx = $random(seed);
      apb(1'b1, OFS_DATA, tx);
      ptx = $random(seed);
      keep = ptx;
      sleep <= 1'b1;
      wakes = 0;
      i_peer.xfer(16);
      sleep <= 1'b0;
      wait_done();
      check(prx, tx, "slave tx");
      check(wakes, 1, "wake");
      ptx = $random(seed);
      i_peer.xfer(16);
      wait_done();
      apb(1'b0, OFS_CONTROL, 8'h00);
      check(rd, 32'h0000_0065, "overflow");
      apb(1'b0, OFS_DATA, 8'h00);
      check(rd, {24'h00_0000, keep}, "old byte");
      $display("test slave done");
      apb(1'b1, OFS_CONTROL, 8'h00);
      apb(1'b1, OFS_CONTROL, {4'b0010, MODE_S_SS});
      ptx = $random(seed);
      i_peer.xfer(8);
      ptx = $random(seed);
      i_peer.xfer(16);
      wait_done();
      apb(1'b0, OFS_DATA, 8'h00);
      check(rd, {24'h00_0000, ptx}, "select abort");
      apb(1'b1, OFS_CONTROL, 8'h20);
      apb(1'b1, OFS_DATA, 8'hA5);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(sck_oe, 0, "abort");
      reset_vals();
      $display("test select and reset done");
      results();
   end
endmodule

//--- sms_rate_gen.sv
// module: master serial clock half period tick generator
`timescale 1ns/100ps
module sms_rate_gen
   import sms_pkg::*;
(
   input  logic       pclk,
   input  logic       presetn,
   input  logic       timer_two_output,
   sms_rate_if.gen    rate
);
   logic [4:0] cnt;
   logic [4:0] limit;

   always_comb begin
      unique case (rate.sel)
         2'h0: limit = LIM_DIV4;
         2'h1: limit = LIM_DIV16;
         2'h2: limit = LIM_DIV64;
         2'h3: limit = LIM_DIV4;
      endcase
   end

   // counter restarts with each transfer so the first half period is full
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 5'h00;
      end else if (!rate.run || cnt == limit) begin
         cnt <= 5'h00;
      end else begin
         cnt <= cnt + 5'h01;
      end
   end

   // timer pulse gives one half period, so a full clock is timer over two
   assign rate.tick = rate.run && ((rate.sel == 2'h3) ? timer_two_output : (cnt == limit));
endmodule

//--- sms_rate_if.sv
// interface: serial clock rate request and half period tick
`timescale 1ns/100ps
interface sms_rate_if;
   logic       run;
   logic [1:0] sel;
   logic       tick;
   modport gen  (input run, input sel, output tick);
   modport user (output run, output sel, input tick);
endinterface
